// *** sas_pkg.sv ***
// Constants and types for the SAR converter sequencer.
// Assumes one system clock domain; the analog core sits outside.
// Contract
// - Low-high-low start pulse launches one conversion
// - Start held high resets converter, clears busy
// - Busy sets once conversion launches
// - Completion clears busy, sets request flag
// - Both enables plus flag raise interrupt
// - Decode four-bit reference select field
// - Analog pin drops digital function and direction
// - Analog pin disconnects pull-high resistor
// - Four sample plus twelve convert clocks
// - Result stored, latched half clock later
// - Internal select zero converts chosen pin
// - Rate select divides system clock 1..128
// - Alignment bit places result left or right
// - Results kept when converter disabled
package sas_pkg;
   localparam int RES_W = 12;
   localparam int PINS = 4;
   localparam logic [3:0] SAMPLE_CYC = 4'h4;
   localparam logic [3:0] CONV_CYC = 4'hc;
   localparam logic [3:0] LAST_CYC = 4'hf;
   localparam logic [6:0] DIV_RST = 7'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [2:0] INSEL_EXT = 3'h0;
   localparam logic [2:0] INSEL_OPA = 3'h4;
   localparam logic [3:0] REF_AVDD = 4'h0;
   localparam logic [3:0] REF_EXT_LO = 4'h1;
   localparam logic [3:0] REF_EXT_HI = 4'h4;
   localparam logic [3:0] REF_BG_LO = 4'ha;
   localparam logic [3:0] REF_BG_HI = 4'hc;
   localparam logic [1:0] SRC_AVDD = 2'h0;
   localparam logic [1:0] SRC_EXT = 2'h1;
   localparam logic [1:0] SRC_BG = 2'h2;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ARMED = 4'b0010,
      ST_RUN = 4'b0100,
      ST_HOLD = 4'b1000
   } sas_state_t;
endpackage

// *** sas_clkdiv.sv ***
// Converter clock tick generator: one tick per selected power-of-two period.
// Assumes the sequencer clears it while the converter is held in reset.
module sas_clkdiv
   import sas_pkg::*;
(
   // Clock and control
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic clr,
   input wire logic [2:0] rate_sel,
   // Ticks
   output logic tick,
   output logic half_tick
);
   typedef struct packed {
      logic [6:0] cnt;
   } sas_div_t;
   sas_div_t s_reg, s_next;
   logic [6:0] top;

   always_comb begin
      top = 7'((8'h01 << rate_sel) - 8'h01);
      s_next = s_reg;
      if (clr || s_reg.cnt >= top) begin
         s_next.cnt = DIV_RST;
      end else begin
         s_next.cnt = s_reg.cnt + 7'h01;
      end
      tick = (s_reg.cnt >= top) && !clr;
      half_tick = (s_reg.cnt == 7'(top >> 1)) && !clr;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_reg <= '{cnt: DIV_RST};
      end else if (ce) begin
         s_reg <= s_next;
      end
   end
endmodule

// *** sas_seq.sv ***
// SAR converter sequencer: start pulse decode, busy/request flags,
// sample and convert phases, result latching and formatting, pin control.
// Assumes a bit-serial SAR core that returns a comparator bit each tick.
module sas_seq
   import sas_pkg::*;
(
   // Clock, reset, enable
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic CE,
   // Control bits
   input wire logic START,
   input wire logic CONVERTER_POWER_ENABLE,
   input wire logic RESULT_ALIGNMENT_SELECT,
   input wire logic [2:0] CONV_CLOCK_RATE_SELECT,
   input wire logic [2:0] INTERNAL_INPUT_SELECT,
   input wire logic [1:0] EXTERNAL_CHANNEL_SELECT,
   input wire logic [3:0] REFERENCE_SELECT,
   input wire logic GLOBAL_INTERRUPT_ENABLE,
   input wire logic CONVERSION_INTERRUPT_ENABLE,
   input wire logic FLAG_CLEAR,
   input wire logic [PINS-1:0] ANALOG_PIN_SELECT,
   input wire logic [PINS-1:0] PULL_HIGH_ENABLE,
   input wire logic [PINS-1:0] PORT_DIRECTION_REG,
   // Analog core
   input wire logic COMPARATOR,
   output logic CORE_RESET,
   output logic CORE_SAMPLE,
   output logic [RES_W-1:0] CORE_TRIAL,
   output logic [1:0] CORE_CHANNEL,
   output logic CORE_USE_INTERNAL,
   output logic [2:0] CORE_INTERNAL_SRC,
   output logic [1:0] REF_SOURCE,
   output logic [2:0] REF_GAIN,
   // Pins
   output logic [PINS-1:0] PIN_DIGITAL_ENABLE,
   output logic [PINS-1:0] PIN_INPUT_MODE,
   output logic [PINS-1:0] PIN_PULL_HIGH,
   // Status
   output logic CONVERSION_BUSY_FLAG,
   output logic CONVERSION_INTERRUPT_FLAG,
   output logic INT_REQ,
   output logic [7:0] RESULT_HIGH_BYTE,
   output logic [7:0] RESULT_LOW_BYTE
);
   typedef struct packed {
      sas_state_t st;
      logic start_q;
      logic busy;
      logic flag;
      logic irq;
      logic [3:0] phase;
      logic [RES_W-1:0] sar;
      logic [RES_W-1:0] stored;
      logic [7:0] hi;
      logic [7:0] lo;
      logic core_rst;
      logic [1:0] ref_src;
      logic [2:0] ref_gain;
      logic [PINS-1:0] dig_en;
      logic [PINS-1:0] in_mode;
      logic [PINS-1:0] pull;
      logic [1:0] chan;
      logic use_int;
      logic [2:0] int_src;
      logic sample;
      logic [RES_W-1:0] core_trial;
   } sas_seq_t;

   sas_seq_t s_reg, s_next;
   logic tick, half_tick;
   logic [3:0] bitpos;
   logic [RES_W-1:0] trial;

   sas_clkdiv u_div (
      .clk(REF_CLK),
      .rst_n(RSTN),
      .ce(CE),
      .clr(s_reg.st == ST_IDLE || s_reg.st == ST_ARMED),
      .rate_sel(CONV_CLOCK_RATE_SELECT),
      .tick(tick),
      .half_tick(half_tick)
   );

   always_comb begin
      s_next = s_reg;
      s_next.start_q = START;
      bitpos = 4'(LAST_CYC - s_reg.phase);
      trial = s_reg.sar | (12'h001 << bitpos);
      case (s_reg.st)
         ST_IDLE: begin
            if (START && !s_reg.start_q) begin
               s_next.st = ST_ARMED;
               s_next.busy = 1'b0;
               s_next.core_rst = 1'b1;
            end
         end
         ST_ARMED: begin
            if (!START) begin
               s_next.core_rst = 1'b0;
               if (CONVERTER_POWER_ENABLE) begin
                  s_next.st = ST_RUN;
                  s_next.busy = 1'b1;
                  s_next.phase = 4'h0;
                  s_next.sar = '0;
               end else begin
                  s_next.st = ST_IDLE;
               end
            end
         end
         ST_RUN: begin
            if (tick) begin
               if (s_reg.phase >= SAMPLE_CYC) begin
                  s_next.sar = COMPARATOR ? trial : s_reg.sar;
               end
               s_next.phase = s_reg.phase + 4'h1;
               if (s_reg.phase == LAST_CYC) begin
                  s_next.st = ST_HOLD;
                  s_next.stored = COMPARATOR ? trial : s_reg.sar;
                  s_next.busy = 1'b0;
                  s_next.flag = 1'b1;
               end
            end
         end
         ST_HOLD: begin
            if (half_tick) begin
               s_next.st = ST_IDLE;
               if (RESULT_ALIGNMENT_SELECT) begin
                  s_next.hi = {4'h0, s_reg.stored[11:8]};
                  s_next.lo = s_reg.stored[7:0];
               end else begin
                  s_next.hi = s_reg.stored[11:4];
                  s_next.lo = {s_reg.stored[3:0], 4'h0};
               end
            end
         end
         default: s_next.st = ST_IDLE;
      endcase
      // A rising start in any state but idle aborts; during hold it disturbs the stored word
      if (START && !s_reg.start_q && s_reg.st != ST_IDLE) begin
         s_next.st = ST_ARMED;
         s_next.busy = 1'b0;
         s_next.core_rst = 1'b1;
         if (s_reg.st == ST_HOLD) begin
            s_next.stored = s_reg.sar ^ s_reg.stored;
         end
      end
      // Set beats clear so a completion coinciding with a clear is kept
      if (FLAG_CLEAR && !(s_reg.st == ST_RUN && s_next.st == ST_HOLD)) begin
         s_next.flag = 1'b0;
      end
      s_next.irq = s_next.flag && CONVERSION_INTERRUPT_ENABLE && GLOBAL_INTERRUPT_ENABLE;
      // Reference decode; unlisted codes fall back to the supply
      s_next.ref_src = SRC_AVDD;
      s_next.ref_gain = 3'h1;
      if (REFERENCE_SELECT >= REF_EXT_LO && REFERENCE_SELECT <= REF_EXT_HI) begin
         s_next.ref_src = SRC_EXT;
         s_next.ref_gain = 3'(REFERENCE_SELECT);
      end else if (REFERENCE_SELECT >= REF_BG_LO && REFERENCE_SELECT <= REF_BG_HI) begin
         s_next.ref_src = SRC_BG;
         s_next.ref_gain = 3'(REFERENCE_SELECT - 4'h8);
      end
      s_next.dig_en = ~ANALOG_PIN_SELECT;
      s_next.in_mode = ANALOG_PIN_SELECT | PORT_DIRECTION_REG;
      s_next.pull = PULL_HIGH_ENABLE & ~ANALOG_PIN_SELECT;
      // Core steering is registered; the trial word is built from next-state values, one clock ahead, so it meets the next tick
      s_next.chan = EXTERNAL_CHANNEL_SELECT;
      s_next.use_int = (INTERNAL_INPUT_SELECT != INSEL_EXT) && (INTERNAL_INPUT_SELECT != INSEL_OPA);
      s_next.int_src = INTERNAL_INPUT_SELECT;
      s_next.sample = (s_next.st == ST_RUN) && (s_next.phase < SAMPLE_CYC);
      s_next.core_trial = s_next.sar | (12'h001 << 4'(LAST_CYC - s_next.phase));
   end

   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         s_reg <= '{st: ST_IDLE, start_q: 1'b0, busy: 1'b0, flag: 1'b0, irq: 1'b0,
                    phase: 4'h0, sar: '0, stored: '0, hi: BYTE_RST, lo: BYTE_RST,
                    core_rst: 1'b0, ref_src: SRC_AVDD, ref_gain: 3'h1,
                    dig_en: '1, in_mode: '0, pull: '0, chan: 2'h0, use_int: 1'b0,
                    int_src: INSEL_EXT, sample: 1'b0, core_trial: '0};
      end else if (CE) begin
         s_reg <= s_next;
      end
   end

   assign CORE_RESET = s_reg.core_rst;
   assign CORE_SAMPLE = s_reg.sample;
   assign CORE_TRIAL = s_reg.core_trial;
   assign CORE_CHANNEL = s_reg.chan;
   assign CORE_USE_INTERNAL = s_reg.use_int;
   assign CORE_INTERNAL_SRC = s_reg.int_src;
   assign REF_SOURCE = s_reg.ref_src;
   assign REF_GAIN = s_reg.ref_gain;
   assign PIN_DIGITAL_ENABLE = s_reg.dig_en;
   assign PIN_INPUT_MODE = s_reg.in_mode;
   assign PIN_PULL_HIGH = s_reg.pull;
   assign CONVERSION_BUSY_FLAG = s_reg.busy;
   assign CONVERSION_INTERRUPT_FLAG = s_reg.flag;
   assign INT_REQ = s_reg.irq;
   assign RESULT_HIGH_BYTE = s_reg.hi;
   assign RESULT_LOW_BYTE = s_reg.lo;

   property p_busy_on_launch;
      @(posedge REF_CLK) disable iff (!RSTN)
      (CE && s_reg.st == ST_ARMED && !START && CONVERTER_POWER_ENABLE) |=> s_reg.busy;
   endproperty
   a_busy_on_launch: assert property (p_busy_on_launch) else $error("busy not set on launch");

   property p_abort;
      @(posedge REF_CLK) disable iff (!RSTN)
      (CE && START && !s_reg.start_q) |=> (!s_reg.busy && s_reg.core_rst);
   endproperty
   a_abort: assert property (p_abort) else $error("start rise did not reset");

   sequence s_finish;
      CE && s_reg.st == ST_RUN && tick && s_reg.phase == LAST_CYC && !(START && !s_reg.start_q);
   endsequence
   property p_done;
      @(posedge REF_CLK) disable iff (!RSTN)
      s_finish |=> (!s_reg.busy && s_reg.flag);
   endproperty
   a_done: assert property (p_done) else $error("completion flags wrong");

   property p_irq;
      @(posedge REF_CLK) disable iff (!RSTN)
      CE |=> (INT_REQ == (CONVERSION_INTERRUPT_FLAG && $past(CONVERSION_INTERRUPT_ENABLE)
                          && $past(GLOBAL_INTERRUPT_ENABLE)));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt request mismatch");

   property p_sticky;
      @(posedge REF_CLK) disable iff (!RSTN)
      (s_reg.flag && !FLAG_CLEAR && CE) |=> s_reg.flag;
   endproperty
   a_sticky: assert property (p_sticky) else $error("request flag dropped");

   property p_keep_result;
      @(posedge REF_CLK) disable iff (!RSTN)
      (s_reg.st != ST_HOLD) |=> $stable(RESULT_HIGH_BYTE) && $stable(RESULT_LOW_BYTE);
   endproperty
   a_keep_result: assert property (p_keep_result) else $error("result changed outside latch");

   property p_pull;
      @(posedge REF_CLK) disable iff (!RSTN)
      (CE && ANALOG_PIN_SELECT[0]) |=> (!PIN_PULL_HIGH[0] && !PIN_DIGITAL_ENABLE[0]);
   endproperty
   a_pull: assert property (p_pull) else $error("analog pin still digital");

   property p_align;
      @(posedge REF_CLK) disable iff (!RSTN)
      (CE && s_reg.st == ST_HOLD && half_tick && RESULT_ALIGNMENT_SELECT && !START)
         |=> (RESULT_HIGH_BYTE[7:4] == 4'h0);
   endproperty
   a_align: assert property (p_align) else $error("right alignment high nibble not zero");
endmodule

// *** sas_seq_tb_top.sv ***
// Self-checking bench for the SAR converter sequencer.
// Assumes the bench drives every control port itself and holds the comparator bit constant within each conversion.
module sas_seq_tb_top
   import sas_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rstn, ce, start, pwr, align, gie, cie, fclr, comp;
   logic [2:0] rate, insel;
   logic [1:0] chan;
   logic [3:0] refsel;
   logic [PINS-1:0] ana, pull, dir;
   logic core_reset, busy, flag, int_req;
   logic [1:0] core_chan, ref_src;
   logic core_int;
   logic core_sample;
   logic [RES_W-1:0] core_trial;
   logic [2:0] core_src, ref_gain;
   logic [PINS-1:0] pin_den, pin_in, pin_pull;
   logic [7:0] hi, lo;
   int error_cnt = 0;
   int comparisons = 0;
   always #10 ref_clk = ~ref_clk;
   sas_seq DUT (.REF_CLK(ref_clk), .RSTN(rstn), .CE(ce), .START(start), .CONVERTER_POWER_ENABLE(pwr),
      .RESULT_ALIGNMENT_SELECT(align), .CONV_CLOCK_RATE_SELECT(rate), .INTERNAL_INPUT_SELECT(insel),
      .EXTERNAL_CHANNEL_SELECT(chan), .REFERENCE_SELECT(refsel), .GLOBAL_INTERRUPT_ENABLE(gie),
      .CONVERSION_INTERRUPT_ENABLE(cie), .FLAG_CLEAR(fclr), .ANALOG_PIN_SELECT(ana), .PULL_HIGH_ENABLE(pull),
      .PORT_DIRECTION_REG(dir), .COMPARATOR(comp), .CORE_RESET(core_reset),
      .CORE_SAMPLE(core_sample), .CORE_TRIAL(core_trial),
      .CORE_CHANNEL(core_chan), .CORE_USE_INTERNAL(core_int), .CORE_INTERNAL_SRC(core_src),
      .REF_SOURCE(ref_src), .REF_GAIN(ref_gain), .PIN_DIGITAL_ENABLE(pin_den), .PIN_INPUT_MODE(pin_in),
      .PIN_PULL_HIGH(pin_pull), .CONVERSION_BUSY_FLAG(busy), .CONVERSION_INTERRUPT_FLAG(flag),
      .INT_REQ(int_req), .RESULT_HIGH_BYTE(hi), .RESULT_LOW_BYTE(lo));
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Rise, hold one cycle, fall; checks the held-reset state in between
   task automatic pulse();
      start = 1'b1;
      tick();
      tick();
      chk(core_reset, 1);
      chk(busy, 0);
      start = 1'b0;
      tick();
   endtask
   // One full conversion at rate code s; result is all ones or all zeros from the constant comparator
   task automatic convert(input logic [2:0] s);
      int n;
      logic [11:0] r;
      rate = s;
      r = comp ? 12'hfff : 12'h000;
      pulse();
      chk(busy, 1);
      chk(core_sample, 1);
      n = 0;
      while (busy === 1'b1 && n < 5000) begin
         n++;
         tick();
         if (n == (4 << s)) begin
            chk({core_sample, core_trial}, {1'b0, 12'h800});
         end
      end
      chk(n, 16 << s);
      chk(busy, 0);
      chk(flag, 1);
      chk(int_req, gie & cie);
      repeat ((1 << s) + 1) tick();
      chk(hi, align ? {4'h0, r[11:8]} : r[11:4]);
      chk(lo, align ? r[7:0] : {r[3:0], 4'h0});
   endtask
   initial begin
      #400000;
      error_cnt++;
      final_report();
   end
   initial begin
      rstn = 0; ce = 1; start = 0; pwr = 1; align = 0; gie = 0; cie = 0; fclr = 0; comp = 1;
      rate = 0; insel = 0; chan = 0; refsel = 0; ana = 0; pull = 0; dir = 0;
      repeat (8) tick();
      rstn = 1;
      chk({busy, flag, int_req, pin_den, ref_gain}, {3'b000, 4'hf, 3'h1});
      // Codes 5 to 7 keep the converter clock in its accurate band at 50 MHz; the rest only shorten runs
      for (int s = 0; s < 8; s++) begin
         comp = s[0];
         align = s[1];
         convert(s[2:0]);
      end
      // Every enable combination; flag stays set across the next completion
      for (int i = 0; i < 4; i++) begin
         fclr = 1;
         tick();
         fclr = 0;
         {cie, gie} = i[1:0];
         convert(3'h1);
      end
      convert(3'h0);
      chk(flag, 1);
      fclr = 1;
      tick();
      fclr = 0;
      tick();
      chk({flag, int_req}, 2'b00);
      // Start rise in mid-run aborts
      rate = 3'h3;
      pulse();
      repeat (20) tick();
      start = 1;
      repeat (2) tick();
      chk({busy, core_reset}, 2'b01);
      convert(3'h1);
      // Launch with power off is dropped and results survive
      pwr = 0;
      comp = ~comp;
      pulse();
      chk(busy, 0);
      repeat (4) tick();
      chk(hi, 8'h0f);
      chk(lo, 8'hff);
      pwr = 1;
      for (int c = 0; c < 13; c++) begin
         if (c < 5 || c > 9) begin
            // Op-amp enable and pin-share setup sit outside this block and are taken as done
            refsel = c[3:0];
            repeat (2) tick();
            chk(ref_src, c == 0 ? SRC_AVDD : (c < 5 ? SRC_EXT : SRC_BG));
            chk(ref_gain, c == 0 ? 1 : (c < 5 ? c : c - 8));
         end
      end
      ana = 4'h5;
      pull = 4'hf;
      dir = 4'h2;
      insel = 3'h0;
      chan = 2'h2;
      repeat (2) tick();
      chk({pin_den, pin_in, pin_pull}, 12'ha7a);
      chk({core_int, core_chan}, 3'b010);
      insel = 3'h3;
      repeat (2) tick();
      chk({core_int, core_src}, 4'hb);
      // A low enable freezes everything, a start rise included
      ce = 0;
      start = 1;
      repeat (3) tick();
      chk({core_reset, busy}, 2'b00);
      start = 0;
      ce = 1;
      tick();
      final_report();
   end
endmodule
